// >>> pkg/ccdr_map.vh
// timing and geometry constants for the ccd readout sequencer
`ifndef CCDR_MAP_VH
`define CCDR_MAP_VH
// array geometry
`define CCDR_ROWS          12'h808
`define CCDR_HREG_LEN      12'hC1C
`define CCDR_LEAD_DUMMY    12'h00A
`define CCDR_TRAIL_DUMMY   12'h002
`define CCDR_LEAD_DARK     12'h006
`define CCDR_TRAIL_DARK    12'h00A
`define CCDR_DARK_LINES    12'h004
// cycle counts at a 50 ns clock: 20 us vertical step, 1 us setup, 150 ns half pixel
// sized to the divider period so no connection drops bits
`define CCDR_TV_CYC        10'h190
`define CCDR_THS_CYC       10'h014
`define CCDR_HHALF_CYC     10'h003
`define CCDR_TR_CYC        10'h001
`define CCDR_CNT_W         12
`define CCDR_TMR_W         10
// pixel class codes
`define CCDR_CLS_DUMMY     2'h0
`define CCDR_CLS_DARK      2'h1
`define CCDR_CLS_ACTIVE    2'h2
`endif

// >>> rtl/ccdr_divider.v
// divider producing one-cycle enable pulses after a programmable count
`timescale 1ns/1ps
`default_nettype none
`include "ccdr_map.vh"
module ccdr_divider (
   // clock and reset
   input  wire                   clk,
   input  wire                   sys_rst,
   // control
   input  wire                   restart,
   input  wire [`CCDR_TMR_W-1:0] period,
   // pulse out
   output wire                   tick
);
   reg [`CCDR_TMR_W-1:0] count;
   assign tick = (count == period - 1'b1) && !restart;
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         count <= {`CCDR_TMR_W{1'b0}};
      end else if (restart || tick) begin
         count <= {`CCDR_TMR_W{1'b0}};
      end else begin
         count <= count + 1'b1;
      end
   end
endmodule // ccdr_divider
`default_nettype wire

// >>> rtl/ccdr_sequencer.v
// readout sequencer driving the phase and reset clocks of a two-phase ccd
`timescale 1ns/1ps
`default_nettype none
`include "ccdr_map.vh"
module ccdr_sequencer (
   // clock and reset
   input  wire                   clk,
   input  wire                   sys_rst,
   // user control
   input  wire                   expose_start,
   input  wire                   expose_end,
   output wire                   busy,
   output reg                    frame_done,
   // ccd clock pins
   output reg                    vertical_phase_one,
   output reg                    vertical_phase_two,
   output reg                    horizontal_phase_one,
   output wire                   horizontal_phase_two,
   output reg                    reset_gate,
   // front end sample strobes and tags
   output reg                    sample_reset,
   output reg                    sample_signal,
   output reg [1:0]              pixel_class,
   output reg [`CCDR_CNT_W-1:0]  pixel_index,
   output reg [`CCDR_CNT_W-1:0]  row_index
);
   localparam ST_IDLE  = 3'h0;
   localparam ST_EXPO  = 3'h1;
   localparam ST_V1    = 3'h2;
   localparam ST_V2    = 3'h3;
   localparam ST_V3    = 3'h4;
   localparam ST_HS    = 3'h5;
   localparam ST_HSHFT = 3'h6;
   localparam ST_DONE  = 3'h7;

   reg  [2:0]              state;
   reg  [2:0]              next_state;
   reg  [`CCDR_CNT_W-1:0]  hcnt;
   reg  [`CCDR_TMR_W-1:0]  period;
   reg                     restart;
   wire                    tick;
   reg                     hphase;
   reg                     rst_phase;
   wire                    rst_tick;
   wire                    rdiv_restart;

   ///////////////////////////////////////////////////////////////////////////
   ccdr_divider u_div (
      .clk     (clk),
      .sys_rst (sys_rst),
      .restart (restart),
      .period  (period),
      .tick    (tick)
   );

   always @* begin
      case (state)
         ST_V1, ST_V2, ST_V3: period = `CCDR_TV_CYC;
         ST_HS:               period = `CCDR_THS_CYC;
         default:             period = `CCDR_HHALF_CYC;
      endcase
   end

   ///////////////////////////////////////////////////////////////////////////
   // phase two is the exact complement of phase one
   assign horizontal_phase_two = ~horizontal_phase_one;
   assign busy = (state != ST_IDLE);

   always @* begin
      next_state = state;
      restart    = 1'b0;
      case (state)
         ST_IDLE: if (expose_start) begin
            next_state = ST_EXPO;
         end
         ST_EXPO: if (expose_end) begin
            next_state = ST_V1;
            restart    = 1'b1;
         end
         ST_V1: if (tick) begin
            next_state = ST_V2;
         end
         ST_V2: if (tick) begin
            next_state = ST_V3;
         end
         ST_V3: if (tick) begin
            next_state = ST_HS;
         end
         ST_HS: if (tick) begin
            next_state = ST_HSHFT;
         end
         ST_HSHFT: if (tick && hphase && hcnt == `CCDR_HREG_LEN - 1'b1) begin
            next_state = (row_index == `CCDR_ROWS - 1'b1) ? ST_DONE : ST_V1;
         end
         ST_DONE: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   ///////////////////////////////////////////////////////////////////////////
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state                <= ST_IDLE;
         vertical_phase_one   <= 1'b0;
         vertical_phase_two   <= 1'b0;
         horizontal_phase_one <= 1'b1;
         hphase               <= 1'b0;
         hcnt                 <= {`CCDR_CNT_W{1'b0}};
         row_index            <= {`CCDR_CNT_W{1'b0}};
         frame_done           <= 1'b0;
      end else begin
         state      <= next_state;
         frame_done <= (state == ST_DONE);
         case (state)
            ST_IDLE, ST_EXPO: begin
               vertical_phase_one   <= 1'b0;
               vertical_phase_two   <= 1'b0;
               horizontal_phase_one <= 1'b1;
               row_index            <= {`CCDR_CNT_W{1'b0}};
            end
            // vertical transfer: v1 high, then v2 high, then v2 falls with h1 high
            ST_V1: if (tick) begin
               vertical_phase_one <= 1'b1;
            end
            ST_V2: if (tick) begin
               vertical_phase_one <= 1'b0;
               vertical_phase_two <= 1'b1;
            end
            ST_V3: if (tick) begin
               horizontal_phase_one <= 1'b1;
               vertical_phase_two   <= 1'b0;
            end
            ST_HS: begin
               hcnt   <= {`CCDR_CNT_W{1'b0}};
               hphase <= 1'b0;
            end
            ST_HSHFT: if (tick) begin
               // h1 low / h2 high, then h1 high / h2 falls: one pixel out
               horizontal_phase_one <= hphase;
               hphase               <= ~hphase;
               if (hphase) begin
                  hcnt <= hcnt + 1'b1;
                  if (hcnt == `CCDR_HREG_LEN - 1'b1) begin
                     row_index <= row_index + 1'b1;
                  end
               end
            end
            default: ;
         endcase
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // reset gate free-runs at the pixel rate, pulsed in the h1-low half
   // held in step during shifting so a pulse follows the last pixel of a row
   assign rdiv_restart = (state == ST_HSHFT);

   ccdr_divider u_rdiv (
      .clk     (clk),
      .sys_rst (sys_rst),
      .restart (rdiv_restart),
      .period  (`CCDR_HHALF_CYC),
      .tick    (rst_tick)
   );

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rst_phase     <= 1'b0;
         reset_gate    <= 1'b0;
         sample_reset  <= 1'b0;
         sample_signal <= 1'b0;
         pixel_class   <= `CCDR_CLS_DUMMY;
         pixel_index   <= {`CCDR_CNT_W{1'b0}};
      end else begin
         if (state == ST_HSHFT) begin
            rst_phase <= 1'b0;
         end else if (rst_tick) begin
            rst_phase <= ~rst_phase;
         end
         // outside readout the gate keeps its own cadence
         if (state == ST_HSHFT) begin
            reset_gate <= tick && !hphase;
         end else begin
            reset_gate <= rst_tick && !rst_phase;
         end
         // reset level after the gate pulse, signal in the same cycle that h2 falls
         // hphase keeps a free-cadence pulse at shift entry from tagging a sample
         sample_reset  <= (state == ST_HSHFT) && reset_gate && hphase;
         sample_signal <= (state == ST_HSHFT) && tick && hphase;
         if ((state == ST_HSHFT) && tick && hphase) begin
            pixel_index <= hcnt;
            if (hcnt < `CCDR_LEAD_DUMMY ||
                hcnt >= `CCDR_HREG_LEN - `CCDR_TRAIL_DUMMY) begin
               pixel_class <= `CCDR_CLS_DUMMY;
            end else if (hcnt < `CCDR_LEAD_DUMMY + `CCDR_LEAD_DARK ||
                         hcnt >= `CCDR_HREG_LEN - `CCDR_TRAIL_DUMMY - `CCDR_TRAIL_DARK ||
                         row_index < `CCDR_DARK_LINES ||
                         row_index >= `CCDR_ROWS - `CCDR_DARK_LINES) begin
               pixel_class <= `CCDR_CLS_DARK;
            end else begin
               pixel_class <= `CCDR_CLS_ACTIVE;
            end
         end
      end
   end
endmodule // ccdr_sequencer
`default_nettype wire

// >>> verif/ccdr_sequencer_sva.sv
// assertions on the ccd readout sequencer ports
`timescale 1ns/1ps
`default_nettype none
`include "ccdr_map.vh"
module ccdr_sequencer_sva (
   // clock, reset and status
   input wire logic clk, sys_rst, busy,
   // ccd clock pins and sample strobes
   input wire logic vertical_phase_one, vertical_phase_two, reset_gate,
   input wire logic horizontal_phase_one, horizontal_phase_two,
   input wire logic sample_reset, sample_signal,
   // pixel tags
   input wire logic [1:0] pixel_class,
   input wire logic [`CCDR_CNT_W-1:0] pixel_index
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////
   property p_low; $rose(busy) |-> (!(vertical_phase_one || vertical_phase_two))[*8]; endproperty
   a_low: assert property (p_low) else $error("vertical moved");
   property p_vord; $fell(vertical_phase_one) |-> $rose(vertical_phase_two); endproperty
   a_vord: assert property (p_vord) else $error("vertical order");
   property p_load;
      $fell(vertical_phase_two) |-> horizontal_phase_one && $past(horizontal_phase_one);
   endproperty
   a_load: assert property (p_load) else $error("row load");
   property p_cmp; horizontal_phase_two != horizontal_phase_one; endproperty
   a_cmp: assert property (p_cmp) else $error("phases equal");
   property p_alt;
      $fell(horizontal_phase_one) |-> ##3 $rose(horizontal_phase_one);
   endproperty
   a_alt: assert property (p_alt) else $error("h phases not alternating");
   property p_sig; $fell(horizontal_phase_two) |-> sample_signal; endproperty
   a_sig: assert property (p_sig) else $error("no signal strobe");
   property p_rg; sample_signal |-> ##[1:5] reset_gate; endproperty
   a_rg: assert property (p_rg) else $error("no reset pulse");
   property p_run; reset_gate |=> !reset_gate ##[1:11] reset_gate; endproperty
   a_run: assert property (p_run) else $error("reset clock stopped");
   property p_cds;
      $fell(horizontal_phase_two) |-> $past(sample_reset) || $past(sample_reset, 2);
   endproperty
   a_cds: assert property (p_cds) else $error("reset level not first");
   property p_dum;
      sample_signal && pixel_index < `CCDR_LEAD_DUMMY |-> pixel_class == `CCDR_CLS_DUMMY;
   endproperty
   a_dum: assert property (p_dum) else $error("dummy class");
   c_start: cover property ($rose(busy));
   c_load: cover property ($fell(vertical_phase_two));
   c_pix: cover property (sample_signal && pixel_index == 12'hC1B);
endmodule // ccdr_sequencer_sva
bind ccdr_sequencer ccdr_sequencer_sva u_sva (
   .clk                  (clk),
   .sys_rst              (sys_rst),
   .busy                 (busy),
   .vertical_phase_one   (vertical_phase_one),
   .vertical_phase_two   (vertical_phase_two),
   .reset_gate           (reset_gate),
   .horizontal_phase_one (horizontal_phase_one),
   .horizontal_phase_two (horizontal_phase_two),
   .sample_reset         (sample_reset),
   .sample_signal        (sample_signal),
   .pixel_class          (pixel_class),
   .pixel_index          (pixel_index)
);
`default_nettype wire

// >>> verif/ccdr_ccd_model.sv
// behavioural model of the two-phase ccd under the sequencer
`timescale 1ns/1ps
`default_nettype none
module ccdr_ccd_model (
   // clear and ccd clock pins
   input wire logic clear, vertical_phase_two, horizontal_phase_one,
   input wire logic horizontal_phase_two, reset_gate,
   // observed state
   output logic [11:0] rows_loaded, packets,
   output logic [1:0] faults
);
   logic full, vfault, hfault;
   assign faults = {hfault, vfault};
   always @(posedge clear or negedge vertical_phase_two)
      if (clear) {vfault, rows_loaded} <= 13'h0000;
      else if (horizontal_phase_one) rows_loaded <= rows_loaded + 12'h001;
      else vfault <= 1'b1;
   // sense node holds one packet until the reset gate clears it
   always @(posedge clear or negedge horizontal_phase_two or posedge reset_gate)
      if (clear) {hfault, full, packets} <= 14'h0000;
      else if (reset_gate) full <= 1'b0;
      else begin
         hfault <= hfault | full;
         full <= 1'b1;
         packets <= packets + 12'h001;
      end
endmodule // ccdr_ccd_model
`default_nettype wire

// >>> verif/ccdr_sequencer_test.sv
// self-checking bench for the ccd readout sequencer
`timescale 1ns/1ps
`default_nettype none
module ccdr_sequencer_test;
   logic clk, sys_rst, expose_start, expose_end, busy, frame_done, vertical_phase_one;
   logic vertical_phase_two, horizontal_phase_one, horizontal_phase_two, reset_gate;
   logic sample_reset, sample_signal;
   logic [1:0] pixel_class, faults;
   logic [11:0] pixel_index, row_index, rows_loaded, packets;
   int error_cnt, checks_done, n;
   ccdr_sequencer DUT (.*);
   ccdr_ccd_model u_ccd (.clear(sys_rst), .*);
   ////////////////////////////////////////////////////////////
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   task automatic check(input logic [11:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic wait_for(ref logic s, input logic v);
      n = 0;
      while (s !== v && n < 25000) begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic pulse(ref logic s);
      s = 1;
      @(negedge clk);
      s = 0;
      @(negedge clk);
   endtask
   task automatic do_reset;
      sys_rst = 1;
      repeat (8) @(negedge clk);
      sys_rst = 0;
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_idle;
      check({vertical_phase_one, vertical_phase_two, horizontal_phase_one, busy}, 4'h2);
      n = 0;
      repeat (60) begin
         @(negedge clk);
         n += reset_gate;
      end
      check(12'(n), 12'h00A);
      $display("t_idle done");
   endtask
   task automatic t_frame;
      pulse(expose_start);
      pulse(expose_start);
      repeat (50) begin
         @(negedge clk);
         check({busy, vertical_phase_one, vertical_phase_two}, 3'h4);
      end
      pulse(expose_end);
      wait_for(vertical_phase_one, 1);
      check(n >= 399 && n <= 401, 1);
      wait_for(vertical_phase_two, 1);
      check(12'(n), 12'h190);
      wait_for(vertical_phase_two, 0);
      check(12'(n), 12'h190);
      check(horizontal_phase_one, 1);
      check(rows_loaded, 12'h001);
      check(frame_done, 0);
      $display("t_frame done");
   endtask
   task automatic t_line;
      int sig, dum, drk, rsm;
      logic [11:0] last;
      sig = 0;
      dum = 0;
      drk = 0;
      rsm = 0;
      last = 12'h000;
      n = 0;
      while (row_index === 12'h000 && n < 30000) begin
         @(negedge clk);
         n++;
         sig += sample_signal;
         dum += sample_signal && pixel_class === 2'h0;
         drk += sample_signal && pixel_class === 2'h1;
         rsm += sample_reset;
         if (sample_signal) last = pixel_index;
      end
      check(12'(rsm), 12'hC1C);
      check(last, 12'hC1B);
      check(frame_done, 0);
      check(12'(sig), 12'hC1C);
      check(12'(dum), 12'h00C);
      check(12'(drk), 12'hC10);
      check(packets, 12'hC1C);
      check(faults, 2'h0);
      $display("t_line done");
   endtask
   task automatic t_abort;
      repeat (700) @(negedge clk);
      do_reset;
      check({busy, vertical_phase_one, vertical_phase_two, horizontal_phase_two}, 4'h0);
      check(row_index, 12'h000);
      pulse(expose_start);
      check(busy, 1);
      $display("t_abort done");
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      #2000000;
      error_cnt++;
      $display("[ERR] %0t timeout", $time);
      tally_and_finish;
   end
   initial begin
      {expose_start, expose_end} = 2'h0;
      error_cnt = 0;
      checks_done = 0;
      do_reset;
      t_idle;
      t_frame;
      t_line;
      t_abort;
      tally_and_finish;
   end
endmodule // ccdr_sequencer_test
`default_nettype wire
